// file: xc_pkg.sv
/*
  Shared constants and types of the instruction execution core: APB
  register map, command word layout, status flag positions, reset values
  and the operation and state enumerations.
  Assumes a 32-bit APB master with byte addresses.
*/
package xc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PC    = 8'h08;
  localparam logic [7:0] ADDR_INFO  = 8'h0C;
  localparam logic [7:0] ADDR_GPR   = 8'h80; // 32 working registers, 0x80..0xFC

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int unsigned CMD_OP_LSB  = 0;  // 5 bits
  localparam int unsigned CMD_REG_LSB = 5;  // 5 bits
  localparam int unsigned CMD_BIT_LSB = 10; // 3 bits
  localparam int unsigned CMD_PTR_LSB = 13; // 2 bits
  localparam int unsigned CMD_IMM_LSB = 15; // 7 bits

  // ----------------------------------------------------------------
  // status flag positions and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // cycle counts and pointer registers
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  typedef enum logic [4:0] {
    OP_NOP, OP_BRANCH_IF_IRQ_ON, OP_BRANCH_IF_IRQ_OFF, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ARITH_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SWAP_NIBBLES,
    OP_FLAG_SET, OP_FLAG_CLEAR, OP_COPY_BIT_TO_TRANSFER, OP_COPY_TRANSFER_TO_BIT,
    OP_SET_OVERFLOW, OP_CLEAR_OVERFLOW, OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY,
    OP_SET_SIGN_FLAG, OP_CLEAR_SIGN_FLAG, OP_LOAD_FROM_POINTER, OP_LOAD_POINTER_OFFSET
  } xc_op_e;

  typedef enum logic [1:0] { PM_PLAIN, PM_POST, PM_PRE, PM_DISP } xc_ptr_mode_e;

  typedef enum logic [1:0] { ST_IDLE, ST_EX1, ST_EX2 } xc_state_e;

  typedef struct packed {
    xc_op_e     op;
    logic [4:0] rd;
    logic [2:0] bsel;
    logic [1:0] ptr;
    logic [6:0] imm;
  } xc_cmd_s;

endpackage

// file: xc_dp_if.sv
/*
  Datapath carrier between the core sequencer and its shift/flag unit and
  address unit.
  Assumes all three modules sit in the same clock domain; pure wires.
*/
interface xc_dp_if;
  import xc_pkg::*;

  xc_op_e       alu_op;
  logic [7:0]   alu_a;
  logic [2:0]   alu_bit;
  logic [7:0]   flags_in;
  logic [7:0]   alu_res;
  logic [7:0]   flags_out;
  logic [15:0]  ptr_val;
  xc_ptr_mode_e ptr_mode;
  logic [5:0]   disp;
  logic [15:0]  eff_addr;
  logic [15:0]  ptr_new;

  modport core (output alu_op, alu_a, alu_bit, flags_in, ptr_val, ptr_mode, disp,
                input alu_res, flags_out, eff_addr, ptr_new);
  modport alu  (input alu_op, alu_a, alu_bit, flags_in, output alu_res, flags_out);
  modport agu  (input ptr_val, ptr_mode, disp, output eff_addr, ptr_new);
endinterface

// file: xc_alu.sv
/*
  Shift, rotate, nibble swap, bit transfer and single flag unit.
  Assumes a combinational caller that registers result and flags itself.
*/
module xc_alu
  import xc_pkg::*;
(
  xc_dp_if.alu dp
);

  // ----------------------------------------------------------------
  // result and flags
  // ----------------------------------------------------------------
  // shifts share one flag update; v is n xor c for all five forms
  always_comb begin
    logic       shf;
    logic       cout;
    logic [7:0] a;
    shf  = 1'b1;
    cout = 1'b0;
    a    = dp.alu_a;
    dp.alu_res   = a;
    dp.flags_out = dp.flags_in;
    case (dp.alu_op)
      OP_LOGIC_SHIFT_LEFT: begin
        dp.alu_res = {a[6:0], 1'b0};
        cout       = a[7];
      end
      OP_LOGIC_SHIFT_RIGHT: begin
        dp.alu_res = {1'b0, a[7:1]};
        cout       = a[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        dp.alu_res = {a[7], a[7:1]};
        cout       = a[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        dp.alu_res = {a[6:0], dp.flags_in[FLAG_C]};
        cout       = a[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        dp.alu_res = {dp.flags_in[FLAG_C], a[7:1]};
        cout       = a[0];
      end
      default: shf = 1'b0;
    endcase
    if (shf) begin
      dp.flags_out[FLAG_C] = cout;
      dp.flags_out[FLAG_Z] = (dp.alu_res == 8'h00);
      dp.flags_out[FLAG_N] = dp.alu_res[7];
      dp.flags_out[FLAG_V] = dp.alu_res[7] ^ cout;
    end
    // nibble swap, flag-only and bit transfer forms
    case (dp.alu_op)
      OP_SWAP_NIBBLES:         dp.alu_res = {a[3:0], a[7:4]};
      OP_FLAG_SET:             dp.flags_out[dp.alu_bit] = 1'b1;
      OP_FLAG_CLEAR:           dp.flags_out[dp.alu_bit] = 1'b0;
      OP_COPY_BIT_TO_TRANSFER: dp.flags_out[FLAG_T] = a[dp.alu_bit];
      OP_COPY_TRANSFER_TO_BIT: dp.alu_res[dp.alu_bit] = dp.flags_in[FLAG_T];
      OP_SET_OVERFLOW:         dp.flags_out[FLAG_V] = 1'b1;
      OP_CLEAR_OVERFLOW:       dp.flags_out[FLAG_V] = 1'b0;
      OP_SET_HALF_CARRY:       dp.flags_out[FLAG_H] = 1'b1;
      OP_CLEAR_HALF_CARRY:     dp.flags_out[FLAG_H] = 1'b0;
      OP_SET_SIGN_FLAG:        dp.flags_out[FLAG_S] = 1'b1;
      OP_CLEAR_SIGN_FLAG:      dp.flags_out[FLAG_S] = 1'b0;
      default: ;
    endcase
  end

endmodule

// file: xc_agu.sv
/*
  Pointer address unit: effective address and updated pointer for the
  indirect loads.
  Assumes the caller writes the new pointer back itself.
*/
module xc_agu
  import xc_pkg::*;
(
  xc_dp_if.agu dp
);

  // ----------------------------------------------------------------
  // address and pointer update
  // ----------------------------------------------------------------
  always_comb begin
    dp.eff_addr = dp.ptr_val;
    dp.ptr_new  = dp.ptr_val;
    case (dp.ptr_mode)
      PM_POST: dp.ptr_new = dp.ptr_val + 16'h0001;
      PM_PRE: begin
        dp.eff_addr = dp.ptr_val - 16'h0001;
        dp.ptr_new  = dp.ptr_val - 16'h0001;
      end
      PM_DISP: dp.eff_addr = dp.ptr_val + {10'h000, dp.disp};
      default: ;
    endcase
  end

endmodule

// file: xc_core.sv
/*
  Instruction execution core for the branch-on-interrupt-flag, I/O bit,
  shift/rotate, flag and pointer-load group, with an APB register slave
  through which software issues commands and inspects state.
  Assumes a single 100 MHz clock, an APB master, and data memory and I/O
  space whose read data is valid combinationally while the read strobe is
  high.
*/
import xc_pkg::*;

// Behaviour
// - branch when interrupt flag set, 1/2 cycles
// - branch when interrupt flag clear, 1/2 cycles
// - set one I/O bit, two cycles
// - clear one I/O bit, two cycles
// - shift left, zero in, flags updated
// - shift right, zero in, flags updated
// - arithmetic shift right keeps top bit
// - rotate left through carry, flags updated
// - rotate right through carry, flags updated
// - swap nibbles, no flags; flag set
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - set or clear overflow flag only
// - set half carry flag only
// - clear half carry flag only
// - set or clear sign flag only
// - load then increment pointer, two cycles
// - decrement pointer then load, two cycles
// - load at pointer plus displacement, two cycles
module xc_core
  import xc_pkg::*;
#(
  parameter int unsigned PC_W  = 16,
  parameter int unsigned IO_AW = 5
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   io_rd_en,
  output logic                   io_wr_en,
  output logic      [IO_AW-1:0]  io_addr,
  output logic      [7:0]        io_wdata,
  input  wire logic [7:0]        io_rdata,
  output logic                   mem_rd_en,
  output logic      [15:0]       mem_addr,
  input  wire logic [7:0]        mem_rdata
);

  typedef struct packed {
    xc_state_e        st;
    xc_cmd_s          cmd;
    logic [7:0]       flags;
    logic [PC_W-1:0]  pc;
    logic [31:0][7:0] gpr;
    logic [15:0]      ptr_new;
    logic [1:0]       last_cyc;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             io_rd_en;
    logic             io_wr_en;
    logic [IO_AW-1:0] io_addr;
    logic [7:0]       io_wdata;
    logic             mem_rd_en;
    logic [15:0]      mem_addr;
  } xc_state_s;

  xc_state_s s_q;
  xc_state_s s_d;
  xc_cmd_s   cmd_now;
  logic      launch;

  xc_dp_if dp ();

  xc_alu u_alu (
    .dp (dp.alu)
  );

  xc_agu u_agu (
    .dp (dp.agu)
  );

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // low register index of the selected pointer pair
  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    case (sel)
      2'h0:    return PTR_X_LO;
      2'h1:    return PTR_Y_LO;
      default: return PTR_Z_LO;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == ADDR_CMD) || (a == ADDR_FLAGS) || (a == ADDR_PC) || (a == ADDR_INFO) ||
           (a[7] && (a[1:0] == 2'h0));
  endfunction

  // ----------------------------------------------------------------
  // command decode and datapath inputs
  // ----------------------------------------------------------------
  // a launching command is decoded straight from the bus so its first
  // memory or I/O strobe can leave on the launch edge
  assign launch = psel && penable && pwrite && s_q.pready && (paddr == ADDR_CMD);

  always_comb begin
    cmd_now = s_q.cmd;
    if (launch) begin
      cmd_now.op   = xc_op_e'(pwdata[CMD_OP_LSB +: 5]);
      cmd_now.rd   = pwdata[CMD_REG_LSB +: 5];
      cmd_now.bsel = pwdata[CMD_BIT_LSB +: 3];
      cmd_now.ptr  = pwdata[CMD_PTR_LSB +: 2];
      cmd_now.imm  = pwdata[CMD_IMM_LSB +: 7];
    end
  end

  assign dp.alu_op   = s_q.cmd.op;
  assign dp.alu_a    = s_q.gpr[s_q.cmd.rd];
  assign dp.alu_bit  = s_q.cmd.bsel;
  assign dp.flags_in = s_q.flags;
  assign dp.ptr_val  = {s_q.gpr[ptr_lo(cmd_now.ptr) + 5'h01], s_q.gpr[ptr_lo(cmd_now.ptr)]};
  assign dp.disp     = cmd_now.imm[5:0];

  // load_pointer_offset always uses the displacement form
  always_comb begin
    if (cmd_now.op == OP_LOAD_POINTER_OFFSET) begin
      dp.ptr_mode = PM_DISP;
    end else begin
      dp.ptr_mode = xc_ptr_mode_e'(cmd_now.imm[1:0] == 2'h3 ? 2'h0 : cmd_now.imm[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [PC_W-1:0] k_ext;
    logic            taken;
    s_d = s_q;
    k_ext = PC_W'(signed'(s_q.cmd.imm));
    taken = 1'b0;
    // strobes are single-cycle pulses
    s_d.io_rd_en  = 1'b0;
    s_d.io_wr_en  = 1'b0;
    s_d.mem_rd_en = 1'b0;

    // apb: answer only while idle, so each access also waits for the
    // running instruction to finish; read data is fixed one edge ahead
    if (psel && penable && !s_q.pready && s_q.st == ST_IDLE) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !mapped(paddr);
      s_d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr[7]) begin
          s_d.prdata = {24'h00_0000, s_q.gpr[paddr[6:2]]};
        end else begin
          case (paddr)
            ADDR_CMD:   s_d.prdata = 32'(s_q.cmd);
            ADDR_FLAGS: s_d.prdata = {24'h00_0000, s_q.flags};
            ADDR_PC:    s_d.prdata = 32'(s_q.pc);
            ADDR_INFO:  s_d.prdata = {30'h0000_0000, s_q.last_cyc};
            default:    s_d.prdata = 32'h0000_0000;
          endcase
        end
      end
    end else if (s_q.pready) begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end

    // writes take effect on the edge where the master sees pready
    if (psel && penable && pwrite && s_q.pready && mapped(paddr)) begin
      if (paddr[7]) begin
        s_d.gpr[paddr[6:2]] = pwdata[7:0];
      end else begin
        case (paddr)
          ADDR_FLAGS: s_d.flags = pwdata[7:0];
          ADDR_PC:    s_d.pc    = pwdata[PC_W-1:0];
          default: ;
        endcase
      end
    end

    // launch: first strobe of I/O and memory forms leaves here
    if (launch) begin
      s_d.cmd = cmd_now;
      s_d.st  = ST_EX1;
      case (cmd_now.op)
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
          s_d.io_rd_en = 1'b1;
          s_d.io_addr  = cmd_now.imm[IO_AW-1:0];
        end
        OP_LOAD_FROM_POINTER, OP_LOAD_POINTER_OFFSET: begin
          s_d.mem_rd_en = 1'b1;
          s_d.mem_addr  = dp.eff_addr;
          s_d.ptr_new   = dp.ptr_new;
        end
        default: ;
      endcase
    end

    case (s_q.st)
      ST_IDLE: ;
      ST_EX1: begin
        s_d.pc       = s_q.pc + {{(PC_W-1){1'b0}}, 1'b1};
        s_d.st       = ST_IDLE;
        s_d.last_cyc = CYC_ONE;
        case (s_q.cmd.op)
          OP_BRANCH_IF_IRQ_ON:  taken = s_q.flags[FLAG_I];
          OP_BRANCH_IF_IRQ_OFF: taken = !s_q.flags[FLAG_I];
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
            // read-modify-write: other bits pass through from the read
            s_d.io_wr_en = 1'b1;
            s_d.io_wdata = io_rdata;
            s_d.io_wdata[s_q.cmd.bsel] = (s_q.cmd.op == OP_IO_BIT_SET);
            s_d.st = ST_EX2;
          end
          OP_LOAD_FROM_POINTER, OP_LOAD_POINTER_OFFSET: begin
            s_d.gpr[s_q.cmd.rd] = mem_rdata;
            s_d.st = ST_EX2;
          end
          OP_NOP: ;
          default: begin
            // results and flags land together on this edge, so the next
            // command always sees them
            s_d.gpr[s_q.cmd.rd] = dp.alu_res;
            s_d.flags = dp.flags_out;
          end
        endcase
        if (taken) begin
          // taken branch spends a second cycle refilling
          s_d.pc = s_q.pc + k_ext + {{(PC_W-1){1'b0}}, 1'b1};
          s_d.st = ST_EX2;
        end
      end
      ST_EX2: begin
        // pointer written after the data, so it wins if rd overlaps it
        // plain and mode-3 loads leave the pointer alone, so a loaded
        // pointer byte is not overwritten by its old value
        if (s_q.cmd.op == OP_LOAD_FROM_POINTER &&
            (s_q.cmd.imm[1:0] == 2'h1 || s_q.cmd.imm[1:0] == 2'h2)) begin
          s_d.gpr[ptr_lo(s_q.cmd.ptr)]         = s_q.ptr_new[7:0];
          s_d.gpr[ptr_lo(s_q.cmd.ptr) + 5'h01] = s_q.ptr_new[15:8];
        end
        s_d.st       = ST_IDLE;
        s_d.last_cyc = CYC_TWO;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.flags <= FLAGS_RST;
      s_q.pc    <= PC_W'(PC_RST);
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign io_rd_en  = s_q.io_rd_en;
  assign io_wr_en  = s_q.io_wr_en;
  assign io_addr   = s_q.io_addr;
  assign io_wdata  = s_q.io_wdata;
  assign mem_rd_en = s_q.mem_rd_en;
  assign mem_addr  = s_q.mem_addr;

endmodule

// file: xc_core_asserts.sv
/*
  Port checker for the execution core.
  Assumes a bind onto xc_core, one clock, rst asynchronous active high.
*/
module xc_core_asserts
  import xc_pkg::*;
#(
  parameter int unsigned IO_AW = 5
) (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             io_rd_en,
  input wire logic             io_wr_en,
  input wire logic [IO_AW-1:0] io_addr,
  input wire logic [7:0]       io_wdata,
  input wire logic [7:0]       io_rdata,
  input wire logic             mem_rd_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // read-modify-write steps on the I/O side
  sequence s_io_read;
    io_rd_en;
  endsequence
  sequence s_io_write;
    io_wr_en && $stable(io_addr);
  endsequence

  a_io_rmw_order: assert property (s_io_read |=> s_io_write)
    else $error("io write did not follow io read");
  a_io_write_cause: assert property (io_wr_en |-> $past(io_rd_en))
    else $error("io write without preceding read");
  // other bits of the I/O byte must come back untouched
  a_io_one_bit: assert property (io_wr_en |-> $countones(io_wdata ^ $past(io_rdata)) <= 1)
    else $error("io write changed more than one bit");
  a_mem_one_pulse: assert property (mem_rd_en |=> !mem_rd_en)
    else $error("memory strobe longer than one cycle");
  a_mem_io_excl: assert property (mem_rd_en |-> !io_rd_en && !io_wr_en)
    else $error("memory and io strobes together");
  a_ready_when_idle: assert property ((io_rd_en || io_wr_en || mem_rd_en) |-> !pready)
    else $error("bus answered while instruction running");
  a_ready_needs_req: assert property (pready |-> psel && penable)
    else $error("ready without access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

// file: xc_mem_model.sv
/*
  Far side of the core: data memory and I/O register space.
  Assumes one-cycle strobes sampled on the rising edge of clk_sys.
*/
module xc_mem_model #(
  parameter int unsigned AW = 5
) (
  input  wire logic          clk_sys,
  input  wire logic          io_rd_en,
  input  wire logic          io_wr_en,
  input  wire logic [AW-1:0] io_addr,
  input  wire logic [7:0]    io_wdata,
  output logic      [7:0]    io_rdata,
  input  wire logic          mem_rd_en,
  input  wire logic [15:0]   mem_addr,
  output logic      [7:0]    mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] io_q [2**AW];
  logic [7:0] mem_byte;

  // known start pattern, shared by the bench's reference
  initial for (int i = 0; i < 2**AW; i++) io_q[i] = 8'(i * 37);

  // io write lands on the strobe edge
  always @(posedge clk_sys) begin
    if (io_wr_en) io_q[io_addr] <= io_wdata;
  end

  // outside a strobe the lines show the inverse, so stale data never passes
  assign mem_byte  = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5;
  assign io_rdata  = io_rd_en ? io_q[io_addr] : ~io_q[io_addr];
  assign mem_rdata = mem_rd_en ? mem_byte : ~mem_byte;
endmodule

// file: tb.sv
/*
  Self-checking bench for the execution core: APB master, reference model.
  Assumes xc_core, xc_mem_model and the checker are compiled before it.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import xc_pkg::*;
  // ----------------------------------------------------------------
  // signals and reference state
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, io_rd_en, io_wr_en, mem_rd_en;
  logic [4:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, mem_rdata;
  logic [15:0] mem_addr;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          seed       = 32'hAD09;
  logic [7:0]  m_gpr [32];
  logic [7:0]  m_io [32];
  logic [7:0]  m_flags;
  logic [15:0] m_pc;
  logic [1:0]  m_cyc;

  xc_core #(.PC_W(16), .IO_AW(5)) u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_rd_en(io_rd_en), .io_wr_en(io_wr_en),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  xc_mem_model #(.AW(5)) u_part (.clk_sys(clk_sys), .io_rd_en(io_rd_en),
    .io_wr_en(io_wr_en), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // 100 MHz clock
  initial forever #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one APB transfer; the request stands until pready is seen at an edge, or is dropped as a failure after 20 edges
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, exp);
  endtask

  // reference execution of one command
  task automatic model_exec(input logic [4:0] op, input logic [4:0] rd, input logic [2:0] b,
                            input logic [1:0] ptr, input logic [6:0] imm);
    logic [7:0]  a, res;
    logic [15:0] p, ea;
    int          pl;
    a     = m_gpr[rd];
    res   = a;
    m_cyc = 2'h1;
    pl    = (ptr == 2'h0) ? 26 : (ptr == 2'h1) ? 28 : 30;
    p     = {m_gpr[pl+1], m_gpr[pl]};
    case (op)
      5'h01, 5'h02: if (m_flags[FLAG_I] == (op == 5'h01)) begin
        m_pc  = m_pc + {{9{imm[6]}}, imm};
        m_cyc = 2'h2;
      end
      5'h03: {m_cyc, m_io[imm[4:0]][b]} = {2'h2, 1'b1};
      5'h04: {m_cyc, m_io[imm[4:0]][b]} = {2'h2, 1'b0};
      5'h05: {m_flags[FLAG_C], res} = {a, 1'b0};
      5'h06: {res, m_flags[FLAG_C]} = {1'b0, a};
      5'h07: {res, m_flags[FLAG_C]} = {a[7], a};
      5'h08: {m_flags[FLAG_C], res} = {a, m_flags[FLAG_C]};
      5'h09: {res, m_flags[FLAG_C]} = {m_flags[FLAG_C], a};
      5'h0A: res = {a[3:0], a[7:4]};
      5'h0B: m_flags[b] = 1'b1;
      5'h0C: m_flags[b] = 1'b0;
      5'h0D: m_flags[FLAG_T] = a[b];
      5'h0E: res[b] = m_flags[FLAG_T];
      5'h0F, 5'h10: m_flags[FLAG_V] = (op == 5'h0F);
      5'h11, 5'h12: m_flags[FLAG_H] = (op == 5'h11);
      5'h13, 5'h14: m_flags[FLAG_S] = (op == 5'h13);
      default: begin
        m_cyc = 2'h2;
        if (op == 5'h16) ea = p + {10'h0, imm[5:0]};
        else if (imm[1:0] == 2'h2) begin
          p  = p - 16'h1;
          ea = p;
        end else begin
          ea = p;
          if (imm[1:0] == 2'h1) p = p + 16'h1;
        end
        res = ea[7:0] ^ ea[15:8] ^ 8'hA5;
      end
    endcase
    if (op >= 5'h05 && op <= 5'h09) begin
      m_flags[FLAG_Z] = (res == 8'h00);
      m_flags[FLAG_N] = res[7];
      m_flags[FLAG_V] = res[7] ^ m_flags[FLAG_C];
    end
    m_pc      = m_pc + 16'h1;
    m_gpr[rd] = res;
    if (op == 5'h15 && (imm[1:0] == 2'h1 || imm[1:0] == 2'h2)) {m_gpr[pl+1], m_gpr[pl]} = p;
  endtask

  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, v;
    logic        e;
    for (int i = 0; i < 32; i++) {m_gpr[i], m_io[i]} = {8'h00, 8'(i * 37)};
    {m_flags, m_pc, m_cyc} = 26'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(ADDR_FLAGS, 32'h0);
    rdc(ADDR_PC, 32'h0);
    // unmapped place and the read-only cycle count
    apb(8'h10, 1'b1, 32'hFF, r, e);
    chk({31'h0, e}, 32'h1);
    apb(8'h10, 1'b0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(ADDR_INFO, 32'h3);
    rdc(ADDR_INFO, 32'h0);
    // every op except NOP in turn with random operands; state carries between commands
    for (int t = 0; t < 220; t++) begin
      v = $random(seed);
      if (v[25]) begin
        m_flags = v[24:17];
        wr(ADDR_FLAGS, {24'h0, m_flags});
      end
      if (v[26]) begin
        m_gpr[v[4:0]] = v[31:24];
        wr(ADDR_GPR + {1'b0, v[4:0], 2'h0}, {24'h0, v[31:24]});
      end
      if (v[28]) begin
        m_pc = v[23:8];
        wr(ADDR_PC, {16'h0, m_pc});
      end
      wr(ADDR_CMD, {10'h0, v[16:10], v[9:8], v[7:5], v[4:0], 5'(1 + t % 22)});
      model_exec(5'(1 + t % 22), v[4:0], v[7:5], v[9:8], v[16:10]);
      rdc(ADDR_FLAGS, {24'h0, m_flags});
      rdc(ADDR_PC, {16'h0, m_pc});
      rdc(ADDR_INFO, {30'h0, m_cyc});
      for (int i = 0; i < 32; i++) begin
        rdc(ADDR_GPR + {1'b0, i[4:0], 2'h0}, {24'h0, m_gpr[i]});
        chk({24'h0, u_part.io_q[i]}, {24'h0, m_io[i]});
      end
    end
    complete_run;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    complete_run;
  end
endmodule

bind xc_core xc_core_asserts #(.IO_AW(IO_AW)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .io_rd_en(io_rd_en), .io_wr_en(io_wr_en), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .mem_rd_en(mem_rd_en));
